// ==== shared/dpc_cfg.svh ====
// dpc_cfg.svh: register offsets, field positions and reset values of the
// converter power-down and transmit-enable control block.
// Assumes a 12-bit register address from the serial control port core.
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define DPC_ADDR_W          12
`define DPC_DATA_W          8
`define DPC_OFS_POWER_DOWN  12'h011
`define DPC_OFS_TXEN_MASK   12'h012
`define DPC_OFS_AMP_SELECT  12'h013

// ************************************************************
// converter_power_down fields
// ************************************************************
`define DPC_BIT_REF_PD      7
`define DPC_BIT_CHAN0_PD    6
`define DPC_BIT_CHAN1_PD    5
`define DPC_BIT_CHAN2_PD    4
`define DPC_BIT_CHAN3_PD    3
`define DPC_PD_WRITABLE     8'hF8
`define DPC_PD_RESET        8'hF8

// ************************************************************
// txen_power_mask fields
// ************************************************************
`define DPC_BIT_MASK_B      7
`define DPC_BIT_MASK_A      6
`define DPC_MASK_WRITABLE   8'hFF
`define DPC_MASK_RESET      8'h00

// ************************************************************
// amplifier_enable_select fields
// ************************************************************
`define DPC_BIT_AMP_PROT    6
`define DPC_BIT_AMP_TXEN    5
`define DPC_BIT_AMP_BLANK   4
`define DPC_BIT_AMP_SW      3
`define DPC_BIT_AMP_SW_LVL  2
`define DPC_BIT_TXEN_SEL    1
`define DPC_BIT_TXEN_LVL    0
`define DPC_AMP_WRITABLE    8'h7F
`define DPC_AMP_RESET       8'h20

`endif

// ==== shared/dpc_pkg.sv ====
// dpc_pkg: types of the power-down and transmit-enable control block.
// Assumes dpc_cfg.svh is on the include path.
`include "dpc_cfg.svh"

package dpc_pkg;

  // ************************************************************
  // register and state types
  // ************************************************************
  typedef logic [`DPC_ADDR_W-1:0] dpc_addr_t;
  typedef logic [`DPC_DATA_W-1:0] dpc_byte_t;

  // whole state of the control block, registered as one word
  typedef struct packed {
    dpc_byte_t  pwr_r;       // converter_power_down
    dpc_byte_t  mask_r;      // txen_power_mask
    dpc_byte_t  amp_r;       // amplifier_enable_select
    dpc_byte_t  rdata_r;     // read data
    logic       ref_pd_r;
    logic [3:0] chan_pd_r;
    logic       amp_en_r;
    logic [1:0] txen_lvl_r;
  } dpc_state_t;

endpackage : dpc_pkg

// ==== hdl/dpc_pair_gate.sv ====
// dpc_pair_gate: effective power-down of one I/Q channel pair.
// Assumes all inputs are synchronous levels in the register clock domain.
`timescale 1ns/1ps

module dpc_pair_gate (
  // per-channel power-down bits, [0] = I, [1] = Q
  input  wire logic [1:0] chan_pd_bits,
  // pair masking
  input  wire logic       pair_mask,
  input  wire logic       pair_txen,
  // result
  output logic      [1:0] chan_pd_eff
);

  // own bit wins; the mask only adds power-down while the pair is idle
  always_comb begin
    chan_pd_eff = chan_pd_bits | {2{pair_mask & ~pair_txen}};
  end

endmodule : dpc_pair_gate

// ==== hdl/dpc_power_ctrl.sv ====
// dpc_power_ctrl: converter power-down and amplifier enable control.
// Assumes a byte-wide register port from the serial control port core,
// synchronous transmit-enable pins and amplifier sources in the clk domain.
//
// Operation
// - The reference is powered down whenever its bit 7 is set, whatever the masking.
// - Bit 6 powers down the first pair's I channel with priority over masking.
// - Bit 5 powers down the first pair's Q channel with priority over masking.
// - Bit 4 powers down the second pair's I channel with priority over masking.
// - Bit 3 powers down the second pair's Q channel with priority over masking.
// - With the second pair's mask set and transmit enable 1 low, channels 2 and 3 power down.
// - With the first pair's mask set and transmit enable 0 low, channels 0 and 1 power down.
// - With a pair's mask clear, only the channel bits decide that pair's power-down.
// - Amplifier select bit 6 lets the protection error drive the amplifier enable.
// - Amplifier select bit 5 lets the transmit-enable machine drive the amplifier enable.
// - Amplifier select bit 4 lets the blanking machine drive the amplifier enable.
// - Amplifier select bit 3 gives software the amplifier enable, at the level of bit 2.
// - With bit 1 set, the internal transmit-enable level is bit 0 instead of the pins.
`timescale 1ns/1ps
`include "dpc_cfg.svh"

module dpc_power_ctrl (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register port from the serial control core
  input  wire dpc_pkg::dpc_addr_t reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire dpc_pkg::dpc_byte_t reg_wdata,
  output dpc_pkg::dpc_byte_t      reg_rdata,
  // transmit-enable pins driven by the host
  input  wire logic               transmit_enable_pin0,
  input  wire logic               transmit_enable_pin1,
  // amplifier enable sources
  input  wire logic               protect_error,
  input  wire logic               txen_fsm_amp,
  input  wire logic               blanking_fsm_amp,
  // power and enable outputs
  output logic                    reference_power_down,
  output logic [3:0]              chan_power_down,
  output logic                    amp_enable,
  output logic [1:0]              transmit_enable_level
);
  import dpc_pkg::*;

  dpc_state_t st_r;
  dpc_state_t st_nxt;
  logic [1:0] txen_lvl;
  logic [3:0] chan_pd_bits;
  logic [1:0] pair_mask;
  logic [3:0] chan_pd_eff;
  logic       amp_term_ok;
  logic       amp_any_sel;

  // ************************************************************
  // transmit-enable level and per-pair gating
  // ************************************************************

  // software level drives both pairs, so one write can release both at once
  assign txen_lvl = st_r.amp_r[`DPC_BIT_TXEN_SEL] ?
                    {2{st_r.amp_r[`DPC_BIT_TXEN_LVL]}} :
                    {transmit_enable_pin1, transmit_enable_pin0};

  // channel order: [0] chan0 I, [1] chan1 Q, [2] chan2 I, [3] chan3 Q
  assign chan_pd_bits = {st_r.pwr_r[`DPC_BIT_CHAN3_PD], st_r.pwr_r[`DPC_BIT_CHAN2_PD],
                         st_r.pwr_r[`DPC_BIT_CHAN1_PD], st_r.pwr_r[`DPC_BIT_CHAN0_PD]};
  assign pair_mask    = {st_r.mask_r[`DPC_BIT_MASK_B], st_r.mask_r[`DPC_BIT_MASK_A]};

  // one gate per pair; pair 0 uses pin 0, pair 1 uses pin 1
  for (genvar p = 0; p < 2; p++) begin : g_pair
    dpc_pair_gate u_gate (
      .chan_pd_bits (chan_pd_bits[2*p+1:2*p]),
      .pair_mask    (pair_mask[p]),
      .pair_txen    (txen_lvl[p]),
      .chan_pd_eff  (chan_pd_eff[2*p+1:2*p])
    );
  end

  // ************************************************************
  // amplifier enable selection
  // ************************************************************

  // every selected source must agree, so any one of them can hold the
  // amplifier off; with no source selected the amplifier stays off
  always_comb begin
    amp_any_sel = |st_r.amp_r[`DPC_BIT_AMP_PROT:`DPC_BIT_AMP_SW];
    amp_term_ok = 1'b1;
    if (st_r.amp_r[`DPC_BIT_AMP_PROT] && protect_error) begin
      amp_term_ok = 1'b0;
    end
    if (st_r.amp_r[`DPC_BIT_AMP_TXEN] && !txen_fsm_amp) begin
      amp_term_ok = 1'b0;
    end
    if (st_r.amp_r[`DPC_BIT_AMP_BLANK] && !blanking_fsm_amp) begin
      amp_term_ok = 1'b0;
    end
    if (st_r.amp_r[`DPC_BIT_AMP_SW] && !st_r.amp_r[`DPC_BIT_AMP_SW_LVL]) begin
      amp_term_ok = 1'b0;
    end
  end

  // ************************************************************
  // next state: register access and output staging
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    // writes; reserved bits are kept at zero where they are read-only
    if (reg_wr) begin
      unique case (reg_addr)
        `DPC_OFS_POWER_DOWN: st_nxt.pwr_r  = reg_wdata & `DPC_PD_WRITABLE;
        `DPC_OFS_TXEN_MASK:  st_nxt.mask_r = reg_wdata & `DPC_MASK_WRITABLE;
        `DPC_OFS_AMP_SELECT: st_nxt.amp_r  = reg_wdata & `DPC_AMP_WRITABLE;
        default:             st_nxt.pwr_r  = st_r.pwr_r;
      endcase
    end
    // reads: unmapped offsets answer zero
    if (reg_rd) begin
      unique case (reg_addr)
        `DPC_OFS_POWER_DOWN: st_nxt.rdata_r = st_r.pwr_r;
        `DPC_OFS_TXEN_MASK:  st_nxt.rdata_r = st_r.mask_r;
        `DPC_OFS_AMP_SELECT: st_nxt.rdata_r = st_r.amp_r;
        default:             st_nxt.rdata_r = 8'h00;
      endcase
    end
    // outputs follow the stored bits one edge later
    st_nxt.ref_pd_r   = st_r.pwr_r[`DPC_BIT_REF_PD];
    st_nxt.chan_pd_r  = chan_pd_eff;
    st_nxt.amp_en_r   = amp_any_sel & amp_term_ok;
    st_nxt.txen_lvl_r = txen_lvl;
  end

  // single state register; reset powers everything down
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r            <= '0;
      st_r.pwr_r      <= `DPC_PD_RESET;
      st_r.mask_r     <= `DPC_MASK_RESET;
      st_r.amp_r      <= `DPC_AMP_RESET;
      st_r.ref_pd_r   <= 1'b1;
      st_r.chan_pd_r  <= 4'hF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata             = st_r.rdata_r;
  assign reference_power_down  = st_r.ref_pd_r;
  assign chan_power_down       = st_r.chan_pd_r;
  assign amp_enable            = st_r.amp_en_r;
  assign transmit_enable_level = st_r.txen_lvl_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ref_pd_hold_a: assert property (st_r.pwr_r[7] |=> reference_power_down)
    else $error("reference not powered down while its bit is set");
  chan0_pd_a: assert property (st_r.pwr_r[6] |=> chan_power_down[0])
    else $error("channel 0 on while its bit is set");
  chan1_pd_a: assert property (st_r.pwr_r[5] |=> chan_power_down[1])
    else $error("channel 1 on while its bit is set");
  chan2_pd_a: assert property (st_r.pwr_r[4] |=> chan_power_down[2])
    else $error("channel 2 on while its bit is set");
  chan3_pd_a: assert property (st_r.pwr_r[3] |=> chan_power_down[3])
    else $error("channel 3 on while its bit is set");
  pair_b_mask_a: assert property (st_r.mask_r[7] && !txen_lvl[1] |=>
                                  chan_power_down[3:2] == 2'b11)
    else $error("second pair not masked off");
  pair_a_mask_a: assert property (st_r.mask_r[6] && !txen_lvl[0] |=>
                                  chan_power_down[1:0] == 2'b11)
    else $error("first pair not masked off");
  mask_clear_a: assert property (!st_r.mask_r[6] && !st_r.pwr_r[6] && !st_r.pwr_r[5] |=>
                                 chan_power_down[1:0] == 2'b00)
    else $error("first pair off with mask and bits clear");
  prot_block_a: assert property (st_r.amp_r[6] && protect_error |=> !amp_enable)
    else $error("amplifier on during protection error");
  txen_src_a: assert property (st_r.amp_r[6:3] == 4'b0100 |=>
                               amp_enable == $past(txen_fsm_amp))
    else $error("amplifier does not follow transmit-enable machine");
  blank_src_a: assert property (st_r.amp_r[4] && !blanking_fsm_amp |=> !amp_enable)
    else $error("amplifier on while blanking machine holds it off");
  sw_src_a: assert property (st_r.amp_r[6:3] == 4'b0001 |=>
                             amp_enable == $past(st_r.amp_r[2]))
    else $error("amplifier does not follow software level");
  sw_txen_a: assert property (st_r.amp_r[1] |=>
                              transmit_enable_level == {2{$past(st_r.amp_r[0])}})
    else $error("transmit-enable level not taken from software");
  eff_pd_a: assert property (1'b1 |=> chan_power_down ==
                             ($past(chan_pd_bits) |
                              {{2{$past(pair_mask[1]) & ~$past(txen_lvl[1])}},
                               {2{$past(pair_mask[0]) & ~$past(txen_lvl[0])}}}))
    else $error("effective power-down mismatch");

  // counterparts of the checks above: a stuck-high reference power-down
  // would pass every one of those, so the off side is watched too
  ref_pd_clear_a: assert property (!st_r.pwr_r[7] |=> !reference_power_down)
    else $error("reference powered down while its bit is clear");
  mask_clear_b_a: assert property (!st_r.mask_r[7] && !st_r.pwr_r[4] && !st_r.pwr_r[3] |=>
                                   chan_power_down[3:2] == 2'b00)
    else $error("second pair off with mask and bits clear");
  pin_level_a: assert property (!st_r.amp_r[1] |=>
                                transmit_enable_level[0] == $past(transmit_enable_pin0) &&
                                transmit_enable_level[1] == $past(transmit_enable_pin1))
    else $error("transmit-enable level not taken from the pins");
  prot_src_a: assert property (st_r.amp_r[6:3] == 4'b1000 |=>
                               amp_enable != $past(protect_error))
    else $error("amplifier does not follow protection error");
  blank_only_a: assert property (st_r.amp_r[6:3] == 4'b0010 |=>
                                 amp_enable == $past(blanking_fsm_amp))
    else $error("amplifier does not follow blanking machine");
  amp_none_a: assert property (st_r.amp_r[6:3] == 4'b0000 |=> !amp_enable)
    else $error("amplifier on with no source selected");

  masked_off_c: cover property (st_r.mask_r[6] && !txen_lvl[0] && !st_r.pwr_r[6]);
  all_on_c:     cover property (chan_power_down == 4'h0 && !reference_power_down);
  sw_amp_on_c:  cover property (st_r.amp_r[3] && amp_enable);
  sw_txen_c:    cover property (st_r.amp_r[1] && st_r.mask_r[7]);
  prot_trip_c:  cover property (st_r.amp_r[6] && protect_error && !amp_enable);

endmodule : dpc_power_ctrl

// ==== verif/dpc_host_model.sv ====
// dpc_host_model: host logic in front of the power control block, register strobes and pins.
// Assumes its tasks are called 1 ns after a rising clk edge.
`timescale 1ns/1ps

module dpc_host_model (
  // clock
  input  wire logic          clk,
  // register port
  output dpc_pkg::dpc_addr_t reg_addr,
  output logic               reg_wr,
  output logic               reg_rd,
  output dpc_pkg::dpc_byte_t reg_wdata,
  // transmit-enable pins
  output logic               transmit_enable_pin0,
  output logic               transmit_enable_pin1
);
  import dpc_pkg::*;

  // ****************
  // idle levels
  // ****************
  initial begin
    reg_addr             = 12'h000;
    reg_wr               = 1'b0;
    reg_rd               = 1'b0;
    reg_wdata            = 8'h00;
    transmit_enable_pin0 = 1'b1;
    transmit_enable_pin1 = 1'b1;
  end

  // one strobe, taken at the next edge; address and data are inverted afterwards
  // so a stale value can never pass for a live one
  task automatic access(input dpc_addr_t a, input logic w, input dpc_byte_t d);
    reg_addr  = a;
    reg_wr    = w;
    reg_rd    = ~w;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    // one idle edge before returning, so back-to-back calls never move a
    // strobe twice in one time step
    @(posedge clk);
    #1;
  endtask : access

  // pins are steady levels, high lets the pair transmit
  task automatic set_pins(input logic p0, input logic p1);
    transmit_enable_pin0 = p0;
    transmit_enable_pin1 = p1;
  endtask : set_pins
endmodule : dpc_host_model

// ==== verif/dpc_power_ctrl_tb.sv ====
// dpc_power_ctrl_tb: self-checking bench of the power control block.
// Assumes dpc_host_model drives the register port and the pins.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end

module dpc_power_ctrl_tb;
  import dpc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       pe  = 1'b0;
  logic       tf  = 1'b0;
  logic       bf  = 1'b0;
  dpc_addr_t  addr;
  dpc_byte_t  wdata;
  dpc_byte_t  rdata;
  logic       wr;
  logic       rd;
  logic       pin0;
  logic       pin1;
  logic       ref_pd;
  logic       amp_en;
  logic [3:0] chan_pd;
  logic [1:0] lvl;
  int         mismatches  = 0;
  int         comparisons = 0;

  always #50 clk = ~clk;

  dpc_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .transmit_enable_pin0(pin0), .transmit_enable_pin1(pin1));

  dpc_power_ctrl dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .transmit_enable_pin0(pin0),
    .transmit_enable_pin1(pin1), .protect_error(pe), .txen_fsm_amp(tf),
    .blanking_fsm_amp(bf), .reference_power_down(ref_pd), .chan_power_down(chan_pd),
    .amp_enable(amp_en), .transmit_enable_level(lvl));

  // read one register and compare it
  task automatic rd_chk(input dpc_addr_t a, input dpc_byte_t ex);
    host.access(a, 1'b0, 8'h00);
    `CHK("reg_rdata", ex, rdata)
  endtask : rd_chk

  // program all three registers and the inputs, let them land, compare every power and enable output
  task automatic apply(input dpc_byte_t pw, mk, am, input logic p0, p1, e, t, b);
    logic [1:0] lv;
    logic [3:0] cp;
    logic       ae;
    host.access(12'h011, 1'b1, pw);
    host.access(12'h012, 1'b1, mk);
    host.access(12'h013, 1'b1, am);
    host.set_pins(p0, p1);
    pe = e;
    tf = t;
    bf = b;
    repeat (2) @(posedge clk);
    #1;
    lv = am[1] ? {2{am[0]}} : {p1, p0};
    cp = {pw[3], pw[4], pw[5], pw[6]} | {{2{mk[7] & ~lv[1]}}, {2{mk[6] & ~lv[0]}}};
    ae = (|am[6:3]) & (~am[6] | ~e) & (~am[5] | t) & (~am[4] | b) & (~am[3] | am[2]);
    `CHK("reference_power_down", pw[7], ref_pd)
    `CHK("chan_power_down", cp, chan_pd)
    `CHK("amp_enable", ae, amp_en)
    `CHK("transmit_enable_level", lv, lvl)
  endtask : apply

  // reset levels, register reset values, read-only bits and an unmapped address
  task automatic t_reset;
    repeat (2) @(posedge clk);
    #1;
    `CHK("reference_power_down", 1'b1, ref_pd)
    `CHK("chan_power_down", 4'hF, chan_pd)
    `CHK("amp_enable", 1'b0, amp_en)
    `CHK("transmit_enable_level", 2'b00, lvl)
    rst = 1'b0;
    rd_chk(12'h011, 8'hF8);
    rd_chk(12'h012, 8'h00);
    rd_chk(12'h013, 8'h20);
    host.access(12'h011, 1'b1, 8'hFF);
    host.access(12'h012, 1'b1, 8'h3F);
    host.access(12'h013, 1'b1, 8'hFF);
    rd_chk(12'h011, 8'hF8);
    rd_chk(12'h012, 8'h3F);
    rd_chk(12'h013, 8'h7F);
    rd_chk(12'h014, 8'h00);
    $display("test reset_and_access done");
  endtask : t_reset

  // one power-down bit at a time, masks armed but pins high so bits must win
  task automatic t_chan;
    for (int i = 0; i < 6; i++) begin
      apply(8'h80 >> i, 8'hC0, 8'h20, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    end
    $display("test channel_bits done");
  endtask : t_chan

  // every mask and pin combination with channel bits clear
  task automatic t_mask;
    for (int i = 0; i < 16; i++) begin
      apply(8'h00, {i[3:2], 6'h00}, 8'h20, i[0], i[1], 1'b0, 1'b0, 1'b0);
    end
    $display("test pin_masking done");
  endtask : t_mask

  // every amplifier source selection against its source levels
  task automatic t_amp;
    for (int i = 0; i < 128; i++) begin
      apply(8'h00, 8'h00, {1'b0, i[3:0], i[4], 2'b00}, 1'b1, 1'b1,
            i[5], i[6], i[4] ^ i[6]);
    end
    $display("test amp_select done");
  endtask : t_amp

  // software level replaces the pins, also for the masking
  task automatic t_txsel;
    for (int i = 0; i < 8; i++) begin
      apply(8'h00, 8'hC0, {6'h08, 1'b1, i[0]}, i[1], i[2], 1'b0, 1'b0, 1'b0);
    end
    $display("test software_txen done");
  endtask : t_txsel

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    t_reset();
    t_chan();
    t_mask();
    t_amp();
    t_txsel();
    tally_and_finish();
  end

  // about 1300 cycles expected; well over twice that means a hang
  initial begin
    #(3200 * 100);
    mismatches++;
    tally_and_finish();
  end
endmodule : dpc_power_ctrl_tb
